// >>> src/cfr_map.svh
// register offsets, field slices, reset values and limits of the flag block
`ifndef CFR_MAP_SVH
`define CFR_MAP_SVH

// ------------------------------------------------------------
// register map (byte addresses)
// ------------------------------------------------------------
`define CFR_AW 8
`define CFR_FLAG_OFS 8'h00
`define CFR_STAT_OFS 8'h04
`define CFR_CLR_OFS 8'h08
`define CFR_EN_OFS 8'h0C

// ------------------------------------------------------------
// flag word layout and reset
// ------------------------------------------------------------
`define CFR_FLAG_W 12
`define CFR_FLAG_RANGE 11:0
`define CFR_LANE0 7:0
`define CFR_LANE1 11:8
`define CFR_FLAG_RST 12'h000

// ------------------------------------------------------------
// event status layout and reset
// ------------------------------------------------------------
`define CFR_NEV 4
`define CFR_EV_RANGE 3:0
`define CFR_EV_ACC 0
`define CFR_EV_OVF 1
`define CFR_EV_FUF 2
`define CFR_EV_FOF 3
`define CFR_EN_RST 4'h0

// ------------------------------------------------------------
// limits, bus answers and product slices
// ------------------------------------------------------------
`define CFR_PRIO_BLOCK 3'h7
`define CFR_TRAP_SP_MAX 8'h7F
`define CFR_RESP_OKAY 2'h0
`define CFR_RESP_SLVERR 2'h2
`define CFR_PROD_INT 31:16
`define CFR_PROD_FRAC 30:15

`endif

// >>> src/cfr_pkg.sv
// types carried between the flag block and the core around it
package cfr_pkg;

   // flag word, msb first so that a cast matches the register layout
   typedef struct packed {
      logic [1:0] rounding_mode_field;
      logic radix_point_select;
      logic [2:0] processor_priority_level;
      logic float_overflow_flag;
      logic float_underflow_flag;
      logic stack_select;
      logic int_enable;
      logic int_overflow;
      logic bank_select;
   } cfr_flags_type;

   typedef struct packed {
      logic valid;
      logic overflow;
   } cfr_alu_type;

   typedef struct packed {
      logic valid;
      logic underflow;
      logic overflow;
      logic subnormal;
   } cfr_fpu_type;

   typedef struct packed {
      logic valid;
      logic maskable;
      logic [2:0] level;
   } cfr_irq_type;

   typedef struct packed {
      logic valid;
      logic [7:0] vector;
   } cfr_trap_type;

   typedef struct packed {
      logic valid;
      logic [15:0] a;
      logic [15:0] b;
   } cfr_fxmul_type;

endpackage

// >>> src/cfr_sticky.sv
// one sticky status bit: hardware set beats software clear
module cfr_sticky (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic set,
   input wire logic clr,
   output logic q
);

   // set wins so that an event in the clearing cycle is not lost
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= 1'b0;
      end else if (set) begin
         q <= 1'b1;
      end else if (clr) begin
         q <= 1'b0;
      end
   end

   set_wins_a: assert property (@(posedge aclk) disable iff (!aresetn) set |=> q)
      else $error("sticky bit lost a set");

endmodule

// >>> src/cfr_irq_gate.sv
// decides whether a pending interrupt request is taken this cycle
`include "cfr_map.svh"
module cfr_irq_gate (
   input wire cfr_pkg::cfr_irq_type req,
   input wire logic int_enable,
   input wire logic [2:0] processor_priority_level,
   output logic take
);

   // level seven shuts every request out, masked or not
   always_comb begin
      take = req.valid
         && (processor_priority_level != `CFR_PRIO_BLOCK) // R10
         && (!req.maskable || int_enable) // R3
         && (req.level > processor_priority_level); // R9
   end

endmodule

// >>> src/cfr_flags.sv
// processor status flag register with an axi4-lite register port
`include "cfr_map.svh"
// Overview of operation
// [R1] bank bit picks general register set
// [R2] overflow flag follows each alu result
// [R3] maskable requests need interrupt enable set
// [R4] any accepted interrupt clears interrupt enable
// [R5] stack bit: 0 interrupt, 1 user pointer
// [R6] interrupt or trap 0..127 clears stack bit
// [R7] underflow flag on underflow or subnormal operand
// [R8] overflow flag on overflow or subnormal operand
// [R9] request taken only above priority level
// [R10] priority level seven blocks every request
// [R11] radix bit picks product slice written back
// [R12] two-bit rounding field steers the fpu
// [R13] software writes zero to reserved bit
// [R14] rounding bits stored and forwarded unchanged
module cfr_flags (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [`CFR_AW-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [`CFR_AW-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire cfr_pkg::cfr_alu_type alu_result,
   input wire cfr_pkg::cfr_fpu_type fpu_result,
   input wire cfr_pkg::cfr_irq_type irq_request,
   input wire cfr_pkg::cfr_trap_type trap_exec,
   input wire cfr_pkg::cfr_fxmul_type fixed_point_multiply_op,
   output logic [15:0] fixed_point_multiply_result,
   output logic fixed_point_multiply_valid,
   output logic int_accept,
   output logic [2:0] int_accept_level,
   output logic irq,
   output cfr_pkg::cfr_flags_type flags
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   localparam cfr_pkg::cfr_flags_type FLAG_RST = cfr_pkg::cfr_flags_type'(`CFR_FLAG_RST);

   logic bank_select;
   logic int_overflow;
   logic int_enable;
   logic stack_select;
   logic float_underflow_flag;
   logic float_overflow_flag;
   logic [2:0] processor_priority_level;
   logic radix_point_select;
   logic [1:0] rounding_mode_field;
   logic aw_full;
   logic w_full;
   logic [`CFR_AW-1:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic [`CFR_EV_RANGE] ev_status;
   logic [`CFR_EV_RANGE] ev_enable;
   logic next_aw_full;
   logic next_w_full;
   logic next_bvalid;
   logic next_rvalid;
   logic wr_do;
   logic wr_flag;
   logic wr_bad;
   logic take;
   logic trap_sp;
   logic int_taken;
   logic [`CFR_FLAG_RANGE] cur_word;
   cfr_pkg::cfr_flags_type wflag;
   logic [`CFR_EV_RANGE] ev_set;
   logic [`CFR_EV_RANGE] ev_clr;
   logic signed [31:0] product;

   // flag bits face the core as one struct
   assign flags = '{rounding_mode_field: rounding_mode_field,
                    radix_point_select: radix_point_select,
                    processor_priority_level: processor_priority_level,
                    float_overflow_flag: float_overflow_flag,
                    float_underflow_flag: float_underflow_flag,
                    stack_select: stack_select,
                    int_enable: int_enable,
                    int_overflow: int_overflow,
                    bank_select: bank_select};

   // ------------------------------------------------------------
   // axi4-lite write channel
   // ------------------------------------------------------------
   // address and data are held separately so either may arrive first
   always_comb begin
      wr_do = aw_full && w_full && !s_axi_bvalid;
      next_aw_full = (s_axi_awvalid && s_axi_awready) || (aw_full && !wr_do);
      next_w_full = (s_axi_wvalid && s_axi_wready) || (w_full && !wr_do);
      next_bvalid = wr_do || (s_axi_bvalid && !s_axi_bready);
      wr_flag = wr_do && (awaddr_q == `CFR_FLAG_OFS);
      wr_bad = (awaddr_q != `CFR_FLAG_OFS) && (awaddr_q != `CFR_CLR_OFS)
         && (awaddr_q != `CFR_EN_OFS);
   end

   // ready is registered; it drops while a word waits or a response is due
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full <= 1'b0;
         w_full <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `CFR_RESP_OKAY;
      end else begin
         aw_full <= next_aw_full;
         w_full <= next_w_full;
         s_axi_awready <= !next_aw_full && !next_bvalid;
         s_axi_wready <= !next_w_full && !next_bvalid;
         s_axi_bvalid <= next_bvalid;
         if (wr_do) begin
            s_axi_bresp <= wr_bad ? `CFR_RESP_SLVERR : `CFR_RESP_OKAY;
         end
      end
   end

   // payload latches, no reset needed beyond a defined start
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awaddr_q <= '0;
         wdata_q <= '0;
         wstrb_q <= '0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awaddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
      end
   end

   // byte lanes merge the written word into the current flags
   always_comb begin
      cur_word = flags;
      wflag = cfr_pkg::cfr_flags_type'({
         wstrb_q[1] ? wdata_q[`CFR_LANE1] : cur_word[`CFR_LANE1],
         wstrb_q[0] ? wdata_q[`CFR_LANE0] : cur_word[`CFR_LANE0]});
      ev_clr = (wr_do && awaddr_q == `CFR_CLR_OFS && wstrb_q[0])
         ? wdata_q[`CFR_EV_RANGE] : '0;
   end

   // ------------------------------------------------------------
   // axi4-lite read channel
   // ------------------------------------------------------------
   always_comb begin
      next_rvalid = (s_axi_arvalid && s_axi_arready) || (s_axi_rvalid && !s_axi_rready);
   end

   // clear register reads zero; the reserved bit above the flags reads zero
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= `CFR_RESP_OKAY;
      end else begin
         s_axi_arready <= !next_rvalid;
         s_axi_rvalid <= next_rvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rresp <= `CFR_RESP_OKAY;
            case (s_axi_araddr)
               `CFR_FLAG_OFS: s_axi_rdata <= 32'(cur_word); // R13
               `CFR_STAT_OFS: s_axi_rdata <= 32'(ev_status);
               `CFR_CLR_OFS: s_axi_rdata <= '0;
               `CFR_EN_OFS: s_axi_rdata <= 32'(ev_enable);
               default: begin
                  s_axi_rdata <= '0;
                  s_axi_rresp <= `CFR_RESP_SLVERR;
               end
            endcase
         end
      end
   end

   // ------------------------------------------------------------
   // interrupt acceptance
   // ------------------------------------------------------------
   cfr_irq_gate u_gate (
      .req(irq_request),
      .int_enable(int_enable),
      .processor_priority_level(processor_priority_level),
      .take(take)
   );

   // a software trap counts as an accepted interrupt for the enable bit and event status, not for int_accept
   assign trap_sp = trap_exec.valid && (trap_exec.vector <= `CFR_TRAP_SP_MAX);
   assign int_taken = take || trap_exec.valid;

   // acceptance pulse and level towards the sequencer
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         int_accept <= 1'b0;
         int_accept_level <= '0;
      end else begin
         int_accept <= take; // R9
         if (take) begin
            int_accept_level <= irq_request.level;
         end
      end
   end

   // ------------------------------------------------------------
   // flag bits; hardware updates beat a bus write in the same cycle
   // ------------------------------------------------------------
   // bank bit drives the register file select directly
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bank_select <= FLAG_RST.bank_select;
      end else if (wr_flag) begin
         bank_select <= wflag.bank_select; // R1
      end
   end

   // overflow reflects the last alu result, set or cleared
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         int_overflow <= FLAG_RST.int_overflow;
      end else if (alu_result.valid) begin
         int_overflow <= alu_result.overflow; // R2
      end else if (wr_flag) begin
         int_overflow <= wflag.int_overflow;
      end
   end

   // acceptance closes the gate until software reopens it
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         int_enable <= FLAG_RST.int_enable;
      end else if (int_taken) begin
         int_enable <= 1'b0; // R4
      end else if (wr_flag) begin
         int_enable <= wflag.int_enable; // R3
      end
   end

   // traps above the low vector range keep the user pointer
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stack_select <= FLAG_RST.stack_select;
      end else if (take || trap_sp) begin
         stack_select <= 1'b0; // R6
      end else if (wr_flag) begin
         stack_select <= wflag.stack_select; // R5
      end
   end

   // subnormal operands raise both fpu flags
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         float_underflow_flag <= FLAG_RST.float_underflow_flag;
         float_overflow_flag <= FLAG_RST.float_overflow_flag;
      end else if (fpu_result.valid) begin
         float_underflow_flag <= fpu_result.underflow || fpu_result.subnormal; // R7
         float_overflow_flag <= fpu_result.overflow || fpu_result.subnormal; // R8
      end else if (wr_flag) begin
         float_underflow_flag <= wflag.float_underflow_flag;
         float_overflow_flag <= wflag.float_overflow_flag;
      end
   end

   // software-owned fields; rounding bits are passed on as written
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         processor_priority_level <= FLAG_RST.processor_priority_level;
         radix_point_select <= FLAG_RST.radix_point_select;
         rounding_mode_field <= FLAG_RST.rounding_mode_field;
      end else if (wr_flag) begin
         processor_priority_level <= wflag.processor_priority_level; // R9
         radix_point_select <= wflag.radix_point_select;
         rounding_mode_field <= wflag.rounding_mode_field; // R12 R14
      end
   end

   // ------------------------------------------------------------
   // fixed-point multiply write-back
   // ------------------------------------------------------------
   assign product = $signed(fixed_point_multiply_op.a) * $signed(fixed_point_multiply_op.b);

   // radix bit set keeps a q15 result, clear keeps the upper half
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fixed_point_multiply_valid <= 1'b0;
         fixed_point_multiply_result <= '0;
      end else begin
         fixed_point_multiply_valid <= fixed_point_multiply_op.valid;
         if (fixed_point_multiply_op.valid) begin
            fixed_point_multiply_result <= radix_point_select
               ? product[`CFR_PROD_FRAC] : product[`CFR_PROD_INT]; // R11
         end
      end
   end

   // ------------------------------------------------------------
   // event status, enable and interrupt line
   // ------------------------------------------------------------
   always_comb begin
      ev_set = '0;
      ev_set[`CFR_EV_ACC] = int_taken;
      ev_set[`CFR_EV_OVF] = alu_result.valid && alu_result.overflow;
      ev_set[`CFR_EV_FUF] = fpu_result.valid && (fpu_result.underflow || fpu_result.subnormal);
      ev_set[`CFR_EV_FOF] = fpu_result.valid && (fpu_result.overflow || fpu_result.subnormal);
   end

   for (genvar i = 0; i < `CFR_NEV; i++) begin : g_ev
      cfr_sticky u_bit (
         .aclk(aclk),
         .aresetn(aresetn),
         .set(ev_set[i]),
         .clr(ev_clr[i]),
         .q(ev_status[i])
      );
   end

   // line is registered, so it trails the status bit by one cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ev_enable <= `CFR_EN_RST;
         irq <= 1'b0;
      end else begin
         if (wr_do && awaddr_q == `CFR_EN_OFS && wstrb_q[0]) begin
            ev_enable <= wdata_q[`CFR_EV_RANGE];
         end
         irq <= |(ev_status & ev_enable);
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence accept_req_s;
      irq_request.valid && take;
   endsequence

   sequence accept_done_s;
      int_accept && !int_enable && !stack_select;
   endsequence

   bank_by_write_a: assert property ($changed(bank_select) |-> $past(wr_flag)) // R1
      else $error("bank bit moved without a write");
   ovf_track_a: assert property (alu_result.valid |=> int_overflow == $past(alu_result.overflow)) // R2
      else $error("overflow flag does not follow alu");
   mask_gate_a: assert property (int_accept // R3
      |-> !$past(irq_request.maskable) || $past(int_enable))
      else $error("masked request accepted");
   accept_clear_a: assert property (accept_req_s |=> accept_done_s) // R4
      else $error("acceptance left enable or stack bit set");
   trap_stack_a: assert property (trap_sp && !wr_flag |=> !stack_select) // R6
      else $error("low trap kept user stack");
   fpu_under_a: assert property (fpu_result.valid |=> float_underflow_flag // R7
      == ($past(fpu_result.underflow) || $past(fpu_result.subnormal)))
      else $error("underflow flag wrong");
   fpu_over_a: assert property (fpu_result.valid |=> float_overflow_flag // R8
      == ($past(fpu_result.overflow) || $past(fpu_result.subnormal)))
      else $error("overflow flag wrong after fpu");
   level_above_a: assert property (int_accept |-> int_accept_level // R9
      > $past(processor_priority_level))
      else $error("request taken at or below level");
   level_seven_a: assert property (processor_priority_level == `CFR_PRIO_BLOCK |=> !int_accept) // R10
      else $error("request taken at level seven");
   round_keep_a: assert property (wr_flag |=> rounding_mode_field // R14
      == $past(wflag.rounding_mode_field))
      else $error("rounding field not stored as written");

endmodule

// >>> verification/tb_top.sv
// self-checking bench for the processor flag block and its register port
`include "cfr_map.svh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00;
   logic s_axi_awvalid = 1'b0;
   logic s_axi_awready;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_wready;
   logic [1:0] s_axi_bresp;
   logic s_axi_bvalid;
   logic s_axi_bready = 1'b0;
   logic [7:0] s_axi_araddr = 8'h00;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_arready;
   logic [31:0] s_axi_rdata;
   logic [1:0] s_axi_rresp;
   logic s_axi_rvalid;
   logic s_axi_rready = 1'b0;
   cfr_pkg::cfr_alu_type alu_result = '0;
   cfr_pkg::cfr_fpu_type fpu_result = '0;
   cfr_pkg::cfr_irq_type irq_request = '0;
   cfr_pkg::cfr_trap_type trap_exec = '0;
   cfr_pkg::cfr_fxmul_type fixed_point_multiply_op = '0;
   logic [15:0] fixed_point_multiply_result;
   logic fixed_point_multiply_valid;
   logic int_accept;
   logic [2:0] int_accept_level;
   logic irq;
   cfr_pkg::cfr_flags_type flags;
   int miscompares = 0;
   int compares = 0;
   int cycles = 0;

   // ------------------------------------------------------------
   // clock, design and hang guard
   // ------------------------------------------------------------
   // 100 ns period
   always #50 aclk = ~aclk;

   // protection bits are ignored by the block, so they stay tied
   cfr_flags cfr_flags_i (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .alu_result(alu_result), .fpu_result(fpu_result), .irq_request(irq_request),
      .trap_exec(trap_exec), .fixed_point_multiply_op(fixed_point_multiply_op),
      .fixed_point_multiply_result(fixed_point_multiply_result),
      .fixed_point_multiply_valid(fixed_point_multiply_valid),
      .int_accept(int_accept), .int_accept_level(int_accept_level), .irq(irq), .flags(flags)
   );

   // the whole run needs well under a thousand cycles
   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == 4000) begin
         miscompares++;
         end_of_test();
      end
   end

   // ------------------------------------------------------------
   // shared helpers
   // ------------------------------------------------------------
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   // both write channels offered together, each released when taken
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hF;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      chk("write response", {30'h0, er}, {30'h0, s_axi_bresp});
   endtask

   task automatic axi_read(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      chk("read data", ed, s_axi_rdata);
      chk("read response", {30'h0, er}, {30'h0, s_axi_rresp});
   endtask

   // writes the flag word and checks it comes back at the outputs
   task automatic set_flags(input cfr_pkg::cfr_flags_type f);
      axi_write(`CFR_FLAG_OFS, {20'h0, f}, `CFR_RESP_OKAY);
      @(negedge aclk);
      chk("flags", {20'h0, f}, {20'h0, flags});
   endtask

   // a level request held for one cycle, then the one-cycle accept pulse
   task automatic irq_try(input logic m, input logic [2:0] lvl, input logic take);
      @(posedge aclk);
      irq_request <= {1'b1, m, lvl};
      @(posedge aclk);
      irq_request <= '0;
      @(negedge aclk);
      chk("int_accept", {31'h0, take}, {31'h0, int_accept});
      if (take) chk("int_accept_level", {29'h0, lvl}, {29'h0, int_accept_level});
      @(negedge aclk);
      chk("int_accept pulse end", 32'h0, {31'h0, int_accept});
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_reset_and_fields();
      cfr_pkg::cfr_flags_type f;
      chk("flags after reset", 32'h0, {20'h0, flags});
      axi_read(`CFR_FLAG_OFS, 32'h0, `CFR_RESP_OKAY);
      axi_read(`CFR_EN_OFS, 32'h0, `CFR_RESP_OKAY);
      f = '0;
      f.rounding_mode_field = 2'h2;
      f.bank_select = 1'b1;
      f.stack_select = 1'b1;
      set_flags(f);
      f.rounding_mode_field = 2'h1;
      f.bank_select = 1'b0;
      f.stack_select = 1'b0;
      set_flags(f);
      f.rounding_mode_field = 2'h3;
      set_flags(f);
      axi_read(`CFR_FLAG_OFS, {20'h0, f}, `CFR_RESP_OKAY);
      axi_read(8'h10, 32'h0, `CFR_RESP_SLVERR);
      axi_write(8'h14, 32'hFFFF_FFFF, `CFR_RESP_SLVERR);
      $display("test reset_and_fields done");
   endtask

   task automatic t_alu_fpu();
      logic [2:0] c;
      @(posedge aclk);
      alu_result <= 2'h3;
      @(posedge aclk);
      alu_result <= 2'h2;
      @(negedge aclk);
      chk("int_overflow set", 32'h1, {31'h0, flags.int_overflow});
      @(posedge aclk);
      alu_result <= '0;
      @(negedge aclk);
      chk("int_overflow clear", 32'h0, {31'h0, flags.int_overflow});
      // every single cause, then none; cause bits are underflow, overflow, subnormal
      for (int i = 0; i < 4; i++) begin
         c = (i == 3) ? 3'h0 : (3'h4 >> i);
         @(posedge aclk);
         fpu_result <= {1'b1, c};
         @(posedge aclk);
         fpu_result <= '0;
         @(negedge aclk);
         chk("underflow flag", {31'h0, c[2] | c[0]}, {31'h0, flags.float_underflow_flag});
         chk("overflow flag", {31'h0, c[1] | c[0]}, {31'h0, flags.float_overflow_flag});
      end
      $display("test alu_fpu done");
   endtask

   task automatic t_accept();
      cfr_pkg::cfr_flags_type f;
      f = '0;
      f.processor_priority_level = 3'h3;
      f.int_enable = 1'b1;
      f.stack_select = 1'b1;
      set_flags(f);
      irq_try(1'b1, 3'h3, 1'b0);
      irq_try(1'b1, 3'h4, 1'b1);
      chk("enable after accept", 32'h0, {31'h0, flags.int_enable});
      chk("stack after accept", 32'h0, {31'h0, flags.stack_select});
      irq_try(1'b1, 3'h7, 1'b0);
      irq_try(1'b0, 3'h5, 1'b1);
      f.processor_priority_level = 3'h7;
      set_flags(f);
      irq_try(1'b0, 3'h7, 1'b0);
      irq_try(1'b1, 3'h7, 1'b0);
      $display("test accept done");
   endtask

   task automatic t_trap();
      cfr_pkg::cfr_flags_type f;
      f = '0;
      f.int_enable = 1'b1;
      f.stack_select = 1'b1;
      set_flags(f);
      @(posedge aclk);
      trap_exec <= {1'b1, 8'h80};
      @(posedge aclk);
      trap_exec <= '0;
      @(negedge aclk);
      chk("stack after trap 128", 32'h1, {31'h0, flags.stack_select});
      chk("enable after trap", 32'h0, {31'h0, flags.int_enable});
      chk("no accept on trap", 32'h0, {31'h0, int_accept});
      @(posedge aclk);
      trap_exec <= {1'b1, 8'h7F};
      @(posedge aclk);
      trap_exec <= '0;
      @(negedge aclk);
      chk("stack after trap 127", 32'h0, {31'h0, flags.stack_select});
      $display("test trap done");
   endtask

   task automatic t_multiply();
      cfr_pkg::cfr_flags_type f;
      logic [31:0] p;
      logic [15:0] ops [4];
      ops = '{16'h4000, 16'h6000, 16'hC000, 16'h4000};
      f = '0;
      for (int i = 0; i < 4; i++) begin
         f.radix_point_select = i[0];
         set_flags(f);
         p = $signed(ops[i & 2]) * $signed(ops[(i & 2) + 1]);
         @(posedge aclk);
         fixed_point_multiply_op <= {1'b1, ops[i & 2], ops[(i & 2) + 1]};
         @(posedge aclk);
         fixed_point_multiply_op <= '0;
         @(negedge aclk);
         chk("multiply valid", 32'h1, {31'h0, fixed_point_multiply_valid});
         chk("multiply result", {16'h0, i[0] ? p[30:15] : p[31:16]},
             {16'h0, fixed_point_multiply_result});
      end
      $display("test multiply done");
   endtask

   task automatic t_irq_line();
      axi_write(`CFR_CLR_OFS, 32'hF, `CFR_RESP_OKAY);
      axi_read(`CFR_STAT_OFS, 32'h0, `CFR_RESP_OKAY);
      axi_write(`CFR_EN_OFS, 32'h2, `CFR_RESP_OKAY);
      axi_read(`CFR_EN_OFS, 32'h2, `CFR_RESP_OKAY);
      @(posedge aclk);
      alu_result <= 2'h3;
      @(posedge aclk);
      alu_result <= '0;
      repeat (2) @(negedge aclk);
      chk("irq raised", 32'h1, {31'h0, irq});
      axi_read(`CFR_STAT_OFS, 32'h2, `CFR_RESP_OKAY);
      axi_write(`CFR_EN_OFS, 32'h0, `CFR_RESP_OKAY);
      repeat (2) @(negedge aclk);
      chk("irq masked", 32'h0, {31'h0, irq});
      axi_write(`CFR_EN_OFS, 32'h2, `CFR_RESP_OKAY);
      axi_write(`CFR_CLR_OFS, 32'h2, `CFR_RESP_OKAY);
      repeat (2) @(negedge aclk);
      chk("irq cleared", 32'h0, {31'h0, irq});
      axi_read(`CFR_STAT_OFS, 32'h0, `CFR_RESP_OKAY);
      $display("test irq_line done");
   endtask

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      @(negedge aclk);
      t_reset_and_fields();
      t_alu_fpu();
      t_accept();
      t_trap();
      t_multiply();
      t_irq_line();
      end_of_test();
   end
endmodule
